// >>> dv/erf_props.sv
// Checker of answer timing and refusals of the record feature register.
// Assumes it is bound to error_record_feature_reg and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module erf_props
	import err_feat_pkg::*;
#(
	parameter int NUM_RECORDS = 4
) (
	input wire logic                    ref_clk,
	input wire logic                    rst_b,
	input wire err_feat_pkg::mm_req_t   mm_req,
	input wire err_feat_pkg::feat_rsp_t mm_rsp,
	input wire err_feat_pkg::sys_req_t  sys_req,
	input wire err_feat_pkg::feat_rsp_t sys_rsp
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Every request answered one cycle later
	property p_mm_ans; (mm_req.rd || mm_req.wr) |=> mm_rsp.valid; endproperty
	a_mm_ans: assert property (p_mm_ans) else $error("mm answer missing");
	property p_mm_quiet; !(mm_req.rd || mm_req.wr) |=> !mm_rsp.valid; endproperty
	a_mm_quiet: assert property (p_mm_quiet) else $error("mm answer unasked");
	// Data holds between answers, no side effect of idle cycles
	property p_hold; !mm_rsp.valid |-> $stable(mm_rsp.data) && $stable(mm_rsp.hit); endproperty
	a_hold: assert property (p_hold) else $error("mm data moved");
	property p_wr_zero; mm_req.wr && !mm_req.rd |=> mm_rsp.data == '0; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write gave data");
	property p_off_miss; mm_req.rd && mm_req.addr[5:0] != 6'h00 |=> !mm_rsp.hit && mm_rsp.data == '0; endproperty
	a_off_miss: assert property (p_off_miss) else $error("offset miss wrong");
	property p_unimpl;
		mm_req.rd && mm_req.addr[5:0] == 6'h00 && mm_req.addr[13:6] >= NUM_RECORDS |=> mm_rsp.data == '0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("absent record not zero");
	property p_sys_ans; sys_req.rd |=> sys_rsp.valid; endproperty
	a_sys_ans: assert property (p_sys_ans) else $error("sys answer missing");
	property p_sys_half; sys_req.rd && !sys_req.acc[1] |=> sys_rsp.data[63:32] == '0; endproperty
	a_sys_half: assert property (p_sys_half) else $error("half read upper not zero");
	property p_sys_bad;
		sys_req.rd && (sys_req.record_index_pick >= NUM_RECORDS || (sys_req.acc[1] && sys_req.acc[0]))
			|=> !sys_rsp.hit && sys_rsp.data == '0;
	endproperty
	a_sys_bad: assert property (p_sys_bad) else $error("sys refusal wrong");
endmodule // erf_props
bind error_record_feature_reg erf_props #(.NUM_RECORDS(NUM_RECORDS)) u_props (.ref_clk(ref_clk), .rst_b(rst_b),
	.mm_req(mm_req), .mm_rsp(mm_rsp), .sys_req(sys_req), .sys_rsp(sys_rsp));
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench of the record feature register, both read paths.
// Assumes records 0 and 2 are first of their nodes, four records built.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import err_feat_pkg::*;
	// Expected word of a first record, field by field from the top
	localparam int          T_NREC   = 4;
	localparam logic [255:0] T_MASK  = 256'h5;
	localparam logic [31:0] T_IMP_HI = 32'hA5C3_0F1E;
	localparam logic [1:0]  T_IMP_LO = 2'h2;
	localparam logic [1:0]  T_TS     = 2'h1;
	localparam logic [1:0]  T_CI     = 2'h2;
	localparam logic [1:0]  T_INJ    = 2'h1;
	localparam logic [1:0]  T_CEO    = 2'h1;
	localparam logic [1:0]  T_DUI    = 2'h3;
	localparam logic        T_RP     = 1'b1;
	localparam logic [2:0]  T_CEC    = 3'h4;
	localparam logic [1:0]  T_CFI    = 2'h3;
	localparam logic [1:0]  T_UE     = 2'h1;
	localparam logic [1:0]  T_FI     = 2'h2;
	localparam logic [1:0]  T_UI     = 2'h3;
	localparam logic [1:0]  T_LOG    = 2'h2;
	localparam logic [63:0] FW = {T_IMP_HI, 6'h00, T_TS, T_CI, T_INJ, T_CEO, T_DUI, T_RP, T_CEC,
		T_CFI, T_UE, T_FI, T_UI, T_IMP_LO, T_LOG};
	logic      ref_clk = 1'b0;
	logic      rst_b;
	mm_req_t   mm_req;
	sys_req_t  sys_req;
	feat_rsp_t mm_rsp;
	feat_rsp_t sys_rsp;
	int        num_errors = 0;
	int        compares = 0;
	int        seed = 26220;
	logic [31:0] r;
	always #50 ref_clk = ~ref_clk;
	error_record_feature_reg #(.NUM_RECORDS(T_NREC), .FIRST_RECORD_MASK(T_MASK), .IMPDEF_HIGH(T_IMP_HI),
		.IMPDEF_LOW(T_IMP_LO), .TIMESTAMP_SUPPORT(T_TS), .CRITICAL_IRQ(T_CI), .FAULT_INSERT(T_INJ),
		.OVERWRITE_POLICY(T_CEO), .DEFERRED_IRQ(T_DUI), .REPEAT_COUNTER(T_RP), .COUNTER_SIZE(T_CEC),
		.CORR_FAULT_IRQ(T_CFI), .INBAND_ABORT(T_UE), .FAULT_IRQ(T_FI), .RECOVERY_IRQ(T_UI),
		.LOGGING_CONTROL(T_LOG)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .mm_req(mm_req), .mm_rsp(mm_rsp),
		.sys_req(sys_req), .sys_rsp(sys_rsp));
	// Non-first and absent records read all zero
	function automatic logic [63:0] word_of(input logic [7:0] i);
		return (i == 8'h00 || i == 8'h02) ? FW : 64'h0000_0000_0000_0000;
	endfunction
	task automatic chk_bit(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One request on each path in the same cycle, then the answers
	task automatic xfer(input mm_req_t m, input sys_req_t s);
		logic [63:0] w;
		logic        ok;
		@(posedge ref_clk);
		#1;
		mm_req = m;
		sys_req = s;
		@(posedge ref_clk);
		#1;
		mm_req = '0;
		sys_req = '0;
		chk_bit("mm valid", m.rd | m.wr, mm_rsp.valid);
		if (m.rd) begin
			chk_bit("mm hit", m.addr[5:0] == 6'h00, mm_rsp.hit);
			chk_word("mm data", m.addr[5:0] == 6'h00 ? word_of(m.addr[13:6]) : '0, mm_rsp.data);
		end else if (m.wr)
			chk_word("mm write data", '0, mm_rsp.data);
		w = word_of(s.record_index_pick);
		ok = s.record_index_pick < 8'd4 && s.acc != 2'h3;
		chk_bit("sys valid", s.rd, sys_rsp.valid);
		if (s.rd) begin
			chk_bit("sys hit", ok, sys_rsp.hit);
			chk_word("sys data", !ok ? '0 : s.acc == ACC_FULL ? w : s.acc == ACC_HIGH_HALF ?
				{32'h0000_0000, w[63:32]} : {32'h0000_0000, w[31:0]}, sys_rsp.data);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence
	initial begin
		mm_req = '0;
		sys_req = '0;
		rst_b = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1;
		chk_word("mm data at reset", '0, mm_rsp.data);
		chk_bit("sys valid at reset", 1'b0, sys_rsp.valid);
		rst_b = 1'b1;
		// Every record and one past the end, every accessor code
		for (int i = 0; i < 5; i++)
			for (int a = 0; a < 4; a++)
				xfer('{1'b1, 1'b0, 16'(i * 64)}, '{1'b1, feat_accessor_t'(a), 8'(i)});
		$display("corner test done");
		// Write, then read back; off-offset read misses
		xfer('{1'b0, 1'b1, 16'h0000}, '0);
		xfer('{1'b1, 1'b0, 16'h0000}, '0);
		xfer('{1'b1, 1'b0, 16'h0088}, '0);
		$display("write test done");
		// Random traffic on both paths, half of it on register offsets
		repeat (200) begin
			r = $random(seed);
			xfer('{r[0], r[1], r[22] ? {2'b00, r[13:6], 6'h00} : {2'b00, r[15:2]}},
				'{r[16], feat_accessor_t'(r[18:17]), {5'h00, r[21:19]}});
		end
		$display("random test done");
		complete_run();
	end
	// Run should end near 50 us
	initial begin
		#200_000;
		num_errors++;
		$display("watchdog expired");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire

// >>> src/err_feat_defs.svh
// Offsets, field positions and encodings of the record feature register.
// Assumes it is included by its bare name before the package and the module.
`ifndef ERR_FEAT_DEFS_SVH
`define ERR_FEAT_DEFS_SVH

// ----------------------------------------
// Address map
// ----------------------------------------
`define FR_BUS_ADDR_W      16
`define FR_MAX_RECORDS     256
`define FR_SEL_W           8
`define FR_REG_OFFSET      6'h00
`define FR_STRIDE_LSB      6
`define FR_DATA_W          64
`define FR_HALF_W          32

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FR_LOG_LSB         0
`define FR_IMPLO_LSB       2
`define FR_UI_LSB          4
`define FR_FI_LSB          6
`define FR_UE_LSB          8
`define FR_CFI_LSB         10
`define FR_CEC_LSB         12
`define FR_RP_BIT          15
`define FR_DUI_LSB         16
`define FR_CEO_LSB         18
`define FR_INJ_LSB         20
`define FR_CI_LSB          22
`define FR_TS_LSB          24
`define FR_IMPHI_LSB       32

// ----------------------------------------
// Encodings
// ----------------------------------------
`define FR_CODE_NONE       2'h0
`define FR_CODE_ALWAYS     2'h1
`define FR_CODE_CTRL       2'h2
`define FR_CODE_SPLIT      2'h3
`define FR_TS_SYSTIMER     2'h1
`define FR_TS_IMPDEF       2'h2
`define FR_INJ_PRESENT     2'h1
`define FR_CEO_KEEP        2'h0
`define FR_CEO_OVERWRITE   2'h1
`define FR_CEC_NONE        3'h0
`define FR_CEC_8BIT        3'h2
`define FR_CEC_16BIT       3'h4
`define FR_ZERO64          64'h0000_0000_0000_0000

`endif

// >>> src/err_feat_pkg.sv
// Types shared by the record feature register and its users.
// Assumes err_feat_defs.svh is on the include path.
`include "err_feat_defs.svh"

package err_feat_pkg;

	// Which system-register accessor reads the selected record
	typedef enum logic [1:0] {
		ACC_LOW_HALF,
		ACC_HIGH_HALF,
		ACC_FULL
	} feat_accessor_t;

	// Memory-mapped request
	typedef struct packed {
		logic                      rd;
		logic                      wr;
		logic [`FR_BUS_ADDR_W-1:0] addr;
	} mm_req_t;

	// System-register request
	typedef struct packed {
		logic                 rd;
		feat_accessor_t       acc;
		logic [`FR_SEL_W-1:0] record_index_pick;
	} sys_req_t;

	// Answer of either path
	typedef struct packed {
		logic                 valid;
		logic                 hit;
		logic [`FR_DATA_W-1:0] data;
	} feat_rsp_t;

	// Whole module state
	typedef struct packed {
		feat_rsp_t mm;
		feat_rsp_t sys;
	} feat_state_t;

endpackage : err_feat_pkg

// >>> src/error_record_feature_reg.sv
// Read-only feature register of every error record of one node group.
// Assumes requests come from logic on ref_clk; record selector is same-domain.
//
// Contract
// R1 - 64-bit read-only register per record, stride 64
// R2 - System path returns low, high or full word
// R3 - Unimplemented record reads all zeros
// R4 - Non-first record: bits 63:2 read zero
// R5 - First record: impdef high word, 31:26 zero
// R6 - Timestamp field in bits 25:24
// R7 - Critical interrupt field in bits 23:22
// R8 - Fault injection field in bits 21:20
// R9 - Overwrite code 00 keeps first syndrome
// R10 - Overwrite code 01 overwrites unless overflowed
// R11 - Overwrite field zero without a counter
// R12 - Deferred interrupt field, zero without recovery interrupt
// R13 - Repeat counter bit, zero without counter
// R14 - Corrected counter size in bits 14:12
// R15 - Corrected fault interrupt, zero without fault interrupt
// R16 - In-band abort reporting in bits 9:8
// R17 - Fault interrupt field in bits 7:6
// R18 - Recovery interrupt field in bits 5:4
// R19 - First record: impdef constant in bits 3:2
// R20 - Logging control code in bits 1:0
// R21 - Fixed parameters, no reserved codes, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "err_feat_defs.svh"

module error_record_feature_reg
	import err_feat_pkg::*;
#(
	parameter int          NUM_RECORDS       = 4,
	// Bit n set marks record n as the first of its node
	parameter logic [`FR_MAX_RECORDS-1:0] FIRST_RECORD_MASK = 256'h1,
	parameter logic [31:0] IMPDEF_HIGH       = 32'h0000_0000,
	parameter logic [1:0]  IMPDEF_LOW        = 2'h0,
	parameter logic [1:0]  TIMESTAMP_SUPPORT = 2'h0,
	parameter logic [1:0]  CRITICAL_IRQ      = 2'h0,
	parameter logic [1:0]  FAULT_INSERT      = 2'h0,
	parameter logic [1:0]  OVERWRITE_POLICY  = 2'h0,
	parameter logic [1:0]  DEFERRED_IRQ      = 2'h0,
	parameter logic        REPEAT_COUNTER    = 1'b0,
	parameter logic [2:0]  COUNTER_SIZE      = 3'h0,
	parameter logic [1:0]  CORR_FAULT_IRQ    = 2'h0,
	parameter logic [1:0]  INBAND_ABORT      = 2'h0,
	parameter logic [1:0]  FAULT_IRQ         = 2'h0,
	parameter logic [1:0]  RECOVERY_IRQ      = 2'h0,
	parameter logic [1:0]  LOGGING_CONTROL   = 2'h1
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_b,
	input  wire err_feat_pkg::mm_req_t   mm_req,
	output var  err_feat_pkg::feat_rsp_t mm_rsp,
	input  wire err_feat_pkg::sys_req_t  sys_req,
	output var  err_feat_pkg::feat_rsp_t sys_rsp
);
	import err_feat_pkg::*;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// R21 refuse reserved codes
	localparam bit BAD_COUNT = (NUM_RECORDS < 1) || (NUM_RECORDS > `FR_MAX_RECORDS);
	localparam bit BAD_TS    = (TIMESTAMP_SUPPORT == `FR_CODE_SPLIT);
	localparam bit BAD_CI    = (CRITICAL_IRQ == `FR_CODE_SPLIT);
	localparam bit BAD_INJ   = (FAULT_INSERT > `FR_INJ_PRESENT);
	localparam bit BAD_CEO   = (OVERWRITE_POLICY > `FR_CEO_OVERWRITE);
	localparam bit BAD_DUI   = (DEFERRED_IRQ == `FR_CODE_ALWAYS);
	localparam bit BAD_CFI   = (CORR_FAULT_IRQ == `FR_CODE_ALWAYS);
	localparam bit BAD_CEC   = (COUNTER_SIZE != `FR_CEC_NONE) &&
		(COUNTER_SIZE != `FR_CEC_8BIT) && (COUNTER_SIZE != `FR_CEC_16BIT);
	// Zero-code records would make the node look headless
	localparam bit BAD_LOG   = (LOGGING_CONTROL != `FR_CODE_ALWAYS) &&
		(LOGGING_CONTROL != `FR_CODE_CTRL);
	localparam bit BAD_HEAD  = !FIRST_RECORD_MASK[0];

	// R11 policy needs a counter
	localparam bit BAD_CEO_DEP = (COUNTER_SIZE == `FR_CEC_NONE) &&
		(OVERWRITE_POLICY != `FR_CEO_KEEP);
	// R12 deferred control needs recovery interrupt
	localparam bit BAD_DUI_DEP = (RECOVERY_IRQ == `FR_CODE_NONE) &&
		(DEFERRED_IRQ != `FR_CODE_NONE);
	// R13 repeat counter needs a counter
	localparam bit BAD_RP_DEP  = (COUNTER_SIZE == `FR_CEC_NONE) && REPEAT_COUNTER;
	// R15 corrected fault control needs fault interrupt
	localparam bit BAD_CFI_DEP = (FAULT_IRQ == `FR_CODE_NONE) &&
		(CORR_FAULT_IRQ != `FR_CODE_NONE);

	localparam bit BAD_ANY = BAD_COUNT | BAD_TS | BAD_CI | BAD_INJ | BAD_CEO |
		BAD_DUI | BAD_CFI | BAD_CEC | BAD_LOG | BAD_HEAD |
		BAD_CEO_DEP | BAD_DUI_DEP | BAD_RP_DEP | BAD_CFI_DEP;

	// One message per fault plus one summary, so an integrator sees which parameter is wrong
	generate
		if (BAD_COUNT) begin : g_bad_count
			$error("record count out of range");
		end
		if (BAD_TS) begin : g_bad_ts
			$error("timestamp code is reserved");
		end
		if (BAD_CI) begin : g_bad_ci
			$error("critical interrupt code is reserved");
		end
		if (BAD_INJ) begin : g_bad_inj
			$error("fault insertion code is reserved");
		end
		if (BAD_CEO) begin : g_bad_ceo
			$error("overwrite policy code is reserved");
		end
		if (BAD_DUI) begin : g_bad_dui
			$error("deferred interrupt code is reserved");
		end
		if (BAD_CFI) begin : g_bad_cfi
			$error("corrected fault interrupt code is reserved");
		end
		if (BAD_CEC) begin : g_bad_cec
			$error("counter size code is reserved");
		end
		if (BAD_LOG) begin : g_bad_log
			$error("logging control code must be always-on or controllable");
		end
		if (BAD_HEAD) begin : g_bad_head
			$error("record zero must be the first of its node");
		end
		if (BAD_CEO_DEP) begin : g_bad_ceo_dep
			$error("overwrite policy set without a counter");
		end
		if (BAD_DUI_DEP) begin : g_bad_dui_dep
			$error("deferred interrupt set without recovery interrupt");
		end
		if (BAD_RP_DEP) begin : g_bad_rp_dep
			$error("repeat counter set without a counter");
		end
		if (BAD_CFI_DEP) begin : g_bad_cfi_dep
			$error("corrected fault interrupt set without fault interrupt");
		end
		if (BAD_ANY) begin : g_bad_config
			$error("feature parameters use a reserved or inconsistent code");
		end
	endgenerate

	// ----------------------------------------
	// Field map of a first record
	// ----------------------------------------
	// 63:32 implementation word, free for the integrator
	// 31:26 always zero
	// 25:24 timestamp support code
	// 23:22 critical interrupt support code
	// 21:20 fault insertion support code
	// 19:18 corrected overwrite policy code
	// 17:16 deferred recovery interrupt control code
	// 15    repeat counter flag
	// 14:12 corrected counter size code
	// 11:10 corrected fault interrupt control code
	// 9:8   in-band abort report code
	// 7:6   fault interrupt support code
	// 5:4   recovery interrupt support code
	// 3:2   implementation constant
	// 1:0   logging control code, never zero here
	//
	// A non-first record reads all zero, which also makes its
	// logging code zero: software finds the head of a node by
	// scanning for a nonzero low pair.
	//
	// Dependent fields are masked here as well as refused at
	// elaboration, so a relaxed check can never leak a code that
	// claims a control the node lacks.
	//
	// Limitation: the word is the same for every first record;
	// nodes with differing features need separate instances.

	// ----------------------------------------
	// Fixed feature word of a first record
	// ----------------------------------------
	// Built once from parameters, so no register can drift or be written
	function automatic logic [`FR_DATA_W-1:0] head_word();
		logic [`FR_DATA_W-1:0] w;
		w = `FR_ZERO64;
		// R5 impdef high word
		w[`FR_IMPHI_LSB +: 32] = IMPDEF_HIGH;
		// R6 timestamp code
		w[`FR_TS_LSB +: 2] = TIMESTAMP_SUPPORT;
		// R7 critical interrupt code
		w[`FR_CI_LSB +: 2] = CRITICAL_IRQ;
		// R8 injection code
		w[`FR_INJ_LSB +: 2] = FAULT_INSERT;
		// R9 keep-first policy code
		// R10 overwrite policy code
		w[`FR_CEO_LSB +: 2] = OVERWRITE_POLICY;
		// R11 zero without counter
		if (COUNTER_SIZE == `FR_CEC_NONE) begin
			w[`FR_CEO_LSB +: 2] = `FR_CEO_KEEP;
		end
		// R12 deferred interrupt code
		if (RECOVERY_IRQ != `FR_CODE_NONE) begin
			w[`FR_DUI_LSB +: 2] = DEFERRED_IRQ;
		end
		// R13 repeat counter bit
		w[`FR_RP_BIT] = REPEAT_COUNTER && (COUNTER_SIZE != `FR_CEC_NONE);
		// R14 counter size code
		w[`FR_CEC_LSB +: 3] = COUNTER_SIZE;
		// R15 corrected fault code
		if (FAULT_IRQ != `FR_CODE_NONE) begin
			w[`FR_CFI_LSB +: 2] = CORR_FAULT_IRQ;
		end
		// R16 in-band abort code
		w[`FR_UE_LSB +: 2] = INBAND_ABORT;
		// R17 fault interrupt code
		w[`FR_FI_LSB +: 2] = FAULT_IRQ;
		// R18 recovery interrupt code
		w[`FR_UI_LSB +: 2] = RECOVERY_IRQ;
		// R19 impdef low constant
		w[`FR_IMPLO_LSB +: 2] = IMPDEF_LOW;
		// R20 logging control code
		w[`FR_LOG_LSB +: 2] = LOGGING_CONTROL;
		return w;
	endfunction

	localparam logic [`FR_DATA_W-1:0] HEAD_WORD = head_word();

	// ----------------------------------------
	// Per-record lookup
	// ----------------------------------------
	// Shared by both access paths
	function automatic logic [`FR_DATA_W-1:0] record_word(
		input logic [`FR_SEL_W-1:0] idx
	);
		logic [`FR_DATA_W-1:0] w;
		w = `FR_ZERO64;
		// R3 unimplemented reads zero
		if (32'(idx) < NUM_RECORDS) begin
			if (FIRST_RECORD_MASK[idx]) begin
				w = HEAD_WORD;
			end else begin
				// R4 non-first: all zero, bits 1:0 read 00
				// R20 code 00 marks non-first
				w = `FR_ZERO64;
			end
		end
		return w;
	endfunction

	// R1 decode record window offset
	function automatic logic addr_is_feature(
		input logic [`FR_BUS_ADDR_W-1:0] a
	);
		return a[`FR_STRIDE_LSB-1:0] == `FR_REG_OFFSET;
	endfunction

	function automatic logic [`FR_SEL_W-1:0] addr_record(
		input logic [`FR_BUS_ADDR_W-1:0] a
	);
		return a[`FR_STRIDE_LSB +: `FR_SEL_W];
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	feat_state_t state_r;
	feat_state_t state_nxt;

	// Next state of both paths
	always_comb begin
		state_nxt = state_r;
		state_nxt.mm.valid  = 1'b0;
		state_nxt.sys.valid = 1'b0;

		// R1 memory-mapped read
		if (mm_req.rd) begin
			state_nxt.mm.valid = 1'b1;
			state_nxt.mm.hit   = addr_is_feature(mm_req.addr);
			state_nxt.mm.data  = `FR_ZERO64;
			if (addr_is_feature(mm_req.addr)) begin
				state_nxt.mm.data = record_word(addr_record(mm_req.addr));
			end
		end else if (mm_req.wr) begin
			// R21 writes acknowledged, no effect
			state_nxt.mm.valid = 1'b1;
			state_nxt.mm.hit   = addr_is_feature(mm_req.addr);
			state_nxt.mm.data  = `FR_ZERO64;
		end

		// R2 accessor picks the half
		if (sys_req.rd) begin
			state_nxt.sys.valid = 1'b1;
			state_nxt.sys.hit   = 32'(sys_req.record_index_pick) < NUM_RECORDS;
			state_nxt.sys.data  = record_word(sys_req.record_index_pick);
			unique case (sys_req.acc)
				ACC_LOW_HALF: begin
					state_nxt.sys.data[`FR_DATA_W-1:`FR_HALF_W] = 32'h0000_0000;
				end
				ACC_HIGH_HALF: begin
					// High word returned in the low lanes
					// Full word already loaded; move its top into the low lanes
					state_nxt.sys.data[`FR_HALF_W-1:0] =
						state_nxt.sys.data[`FR_DATA_W-1:`FR_HALF_W];
					state_nxt.sys.data[`FR_DATA_W-1:`FR_HALF_W] = 32'h0000_0000;
				end
				ACC_FULL: begin
				end
				default: begin
					// Illegal accessor code answers zero
					state_nxt.sys.data = `FR_ZERO64;
					state_nxt.sys.hit  = 1'b0;
				end
			endcase
		end
	end

	// Register stage; data held between answers
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign mm_rsp  = state_r.mm;
	assign sys_rsp = state_r.sys;

endmodule : error_record_feature_reg

`default_nettype wire
